//--- inc/apt_defines.svh
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH
// What this block does
// - Each pulse-per-second adds one to seconds
// - Divided clock steps fraction; pulse clears it
// - Packets carry type, id, timestamps, trailer
// - Timestamp words filled from live counters
// - Acquired samples leave as signal packets
// - Playback packets lose framing, data forwarded
// - Gate mode ends transfer when gate ends
// - Optional metadata: channel, timestamp, length
// - Source is converter A, B or test

// ==========================================
// Register offsets
`define APT_OFF_CTRL   8'h00
`define APT_OFF_STATUS 8'h04
`define APT_OFF_PLEN   8'h08
`define APT_OFF_SID    8'h0c
`define APT_OFF_TRL    8'h10
`define APT_OFF_DIV    8'h14
`define APT_OFF_SEC    8'h18
`define APT_OFF_FRH    8'h1c
`define APT_OFF_FRL    8'h20
`define APT_OFF_XLEN   8'h24

// ==========================================
// Fields
`define APT_CTRL_RUN  0
`define APT_CTRL_GATE 1
`define APT_CTRL_META 2
`define APT_CTRL_PPS  3
`define APT_CTRL_SRC  5:4
`define APT_ST_OVF    3

// ==========================================
// Reset values and packet constants
`define APT_RST_CTRL  6'h00
`define APT_RST_PLEN  16'h0100
`define APT_RST_SID   32'h0000_0000
`define APT_RST_TRL   32'h0000_0000
`define APT_RST_DIV   16'h0001
`define APT_FRAME_WORDS 16'h0006
`define APT_PKT_TYPE_SIG 4'h1
`define APT_HDR_FLAGS 12'h461
`define APT_RESP_OK   2'b00
`define APT_RESP_ERR  2'b10
`define APT_PB_DATA_IDX 3'h5

`endif

//--- inc/apt_pkg.sv
`default_nettype none
package apt_pkg;
  typedef enum logic [2:0] {
    APT_IDLE = 3'b000,
    APT_HDR  = 3'b001,
    APT_SID  = 3'b011,
    APT_TSI  = 3'b010,
    APT_FRH  = 3'b110,
    APT_FRL  = 3'b111,
    APT_DATA = 3'b101,
    APT_TRL  = 3'b100
  } apt_state_t;

  typedef enum logic [1:0] {
    APT_SRC_ADC0 = 2'h0,
    APT_SRC_ADC1 = 2'h1,
    APT_SRC_TEST = 2'h2,
    APT_SRC_RSVD = 2'h3
  } apt_src_t;
endpackage : apt_pkg
`default_nettype wire

//--- inc/apt_ts_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apt_ts_if;
  logic        pps_en;
  logic        load;
  logic [31:0] load_val;
  logic [15:0] div;
  logic [31:0] sec;
  logic [63:0] frac;
  logic        pps_edge;
  modport ctl (output pps_en, output load, output load_val, output div,
               input sec, input frac, input pps_edge);
  modport ts  (input pps_en, input load, input load_val, input div,
               output sec, output frac, output pps_edge);
endinterface : apt_ts_if
`default_nettype wire

//--- core/apt_ts.sv
`timescale 1ns/1ps
`default_nettype none
`include "apt_defines.svh"
module apt_ts (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pps_in,
  apt_ts_if.ts      t
);
  logic        pps_q;
  logic [31:0] sec_q, sec_d;
  logic [63:0] frac_q, frac_d;
  logic [15:0] dcnt_q, dcnt_d;
  logic        tick;

  // ==========================================
  // Seconds and fraction counters
  assign t.pps_edge = pps_in & ~pps_q;
  assign t.sec      = sec_q;
  assign t.frac     = frac_q;
  // A divide of zero behaves as one
  assign tick = ({1'b0, dcnt_q} + 17'h00001) >= {1'b0, t.div};

  always_comb begin
    sec_d  = sec_q;
    frac_d = frac_q;
    dcnt_d = dcnt_q;
    if (t.load && !t.pps_en) begin
      sec_d = t.load_val;
    end else if (t.pps_edge && t.pps_en) begin
      sec_d = sec_q + 32'h0000_0001;
    end
    if (t.pps_edge) begin
      frac_d = 64'h0;
      dcnt_d = 16'h0000;
    end else if (tick) begin
      frac_d = frac_q + 64'h1;
      dcnt_d = 16'h0000;
    end else begin
      dcnt_d = dcnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pps_q  <= 1'b0;
      sec_q  <= 32'h0;
      frac_q <= 64'h0;
      dcnt_q <= 16'h0000;
    end else begin
      pps_q  <= pps_in;
      sec_q  <= sec_d;
      frac_q <= frac_d;
      dcnt_q <= dcnt_d;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sec_step_a: assert property (t.pps_edge && t.pps_en |=> t.sec == $past(t.sec) + 32'h1)
    else $error("seconds did not step on pulse");
  frac_clear_a: assert property (t.pps_edge |=> t.frac == 64'h0)
    else $error("fraction not cleared on pulse");
  frac_step_a: assert property ((t.div == 16'h0001) && !t.pps_edge |=> t.frac == $past(t.frac) + 64'h1)
    else $error("fraction did not step");
  sec_load_a: assert property (t.load && !t.pps_en |=> t.sec == $past(t.load_val))
    else $error("seconds load lost");
endmodule : apt_ts
`default_nettype wire

//--- core/apt_top.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "apt_defines.svh"
module apt_top #(
  parameter int         DATA_W  = 16,
  parameter logic [7:0] CHAN_ID = 8'h00
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DATA_W-1:0] adc0_data,
  input  wire logic [DATA_W-1:0] adc1_data,
  input  wire logic              sample_valid,
  input  wire logic              gate_in,
  input  wire logic              pps_in,
  output logic [31:0]            dma_tdata,
  output logic                   dma_tvalid,
  input  wire logic              dma_tready,
  output logic                   dma_tlast,
  output logic                   xfer_end,
  output logic                   meta_valid,
  output logic [7:0]             meta_chan,
  output logic [31:0]            meta_sec,
  output logic [63:0]            meta_frac,
  output logic [31:0]            meta_len,
  input  wire logic [31:0]       pb_tdata,
  input  wire logic              pb_tvalid,
  output logic                   pb_tready,
  input  wire logic              pb_tlast,
  output logic [31:0]            tx_data,
  output logic                   tx_valid
);
  apt_ts_if ts_bus ();

  apt_ts u_ts (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pps_in  (pps_in),
    .t       (ts_bus.ts)
  );

  // ==========================================
  // Register bus
  logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d, wr_go;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, mw;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [5:0]  ctrl_q, ctrl_d;
  logic [15:0] plen_q, plen_d, div_q, div_d;
  logic [31:0] sid_q, sid_d, trl_q, trl_d;
  logic        ovf_clr, ts_load;
  logic        ovf_q, ovf_d;
  logic [31:0] xlast_q, xlast_d;
  apt_pkg::apt_state_t st_q, st_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  assign s_axi_awready = !awh_q && !bv_q;
  assign s_axi_wready  = !wh_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign wr_go         = awh_q && wh_q && !bv_q;

  assign ts_bus.pps_en   = ctrl_q[`APT_CTRL_PPS];
  assign ts_bus.load     = ts_load;
  assign ts_bus.load_val = wd_q;
  assign ts_bus.div      = div_q;

  always_comb begin
    awh_d = awh_q;  awa_d = awa_q;  wh_d = wh_q;  wd_d = wd_q;  ws_d = ws_q;
    bv_d  = bv_q && !s_axi_bready;  br_d = br_q;
    rv_d  = rv_q && !s_axi_rready;  rd_d = rd_q;  rr_d = rr_q;
    ctrl_d = ctrl_q;  plen_d = plen_q;  sid_d = sid_q;  trl_d = trl_q;  div_d = div_q;
    ovf_clr = 1'b0;  ts_load = 1'b0;  mw = 32'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = `APT_RESP_OK;
      case (awa_q)
        `APT_OFF_CTRL: begin
          mw     = merge({26'h0, ctrl_q}, wd_q, ws_q);
          ctrl_d = mw[5:0];
        end
        `APT_OFF_STATUS: ovf_clr = wd_q[`APT_ST_OVF] && ws_q[0];
        `APT_OFF_PLEN: begin
          mw     = merge({16'h0, plen_q}, wd_q, ws_q);
          plen_d = mw[15:0];
        end
        `APT_OFF_SID: sid_d = merge(sid_q, wd_q, ws_q);
        `APT_OFF_TRL: trl_d = merge(trl_q, wd_q, ws_q);
        `APT_OFF_DIV: begin
          mw    = merge({16'h0, div_q}, wd_q, ws_q);
          div_d = mw[15:0];
        end
        // Seconds take the whole word; ignored while pulses count
        `APT_OFF_SEC: ts_load = 1'b1;
        default: br_d = `APT_RESP_ERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = `APT_RESP_OK;
      case (s_axi_araddr)
        `APT_OFF_CTRL:   rd_d = {26'h0, ctrl_q};
        `APT_OFF_STATUS: rd_d = {28'h0, ovf_q, st_q};
        `APT_OFF_PLEN:   rd_d = {16'h0, plen_q};
        `APT_OFF_SID:    rd_d = sid_q;
        `APT_OFF_TRL:    rd_d = trl_q;
        `APT_OFF_DIV:    rd_d = {16'h0, div_q};
        `APT_OFF_SEC:    rd_d = ts_bus.sec;
        `APT_OFF_FRH:    rd_d = ts_bus.frac[63:32];
        `APT_OFF_FRL:    rd_d = ts_bus.frac[31:0];
        `APT_OFF_XLEN:   rd_d = xlast_q;
        default: begin
          rd_d = 32'h0;
          rr_d = `APT_RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_q <= 1'b0;  awa_q <= 8'h00;  wh_q <= 1'b0;  wd_q <= 32'h0;  ws_q <= 4'h0;
      bv_q  <= 1'b0;  br_q  <= 2'h0;   rv_q <= 1'b0;  rd_q <= 32'h0;  rr_q <= 2'h0;
      ctrl_q <= `APT_RST_CTRL;  plen_q <= `APT_RST_PLEN;  sid_q <= `APT_RST_SID;
      trl_q  <= `APT_RST_TRL;   div_q  <= `APT_RST_DIV;
    end else begin
      awh_q <= awh_d;  awa_q <= awa_d;  wh_q <= wh_d;  wd_q <= wd_d;  ws_q <= ws_d;
      bv_q  <= bv_d;   br_q  <= br_d;   rv_q <= rv_d;  rd_q <= rd_d;  rr_q <= rr_d;
      ctrl_q <= ctrl_d;  plen_q <= plen_d;  sid_q <= sid_d;
      trl_q  <= trl_d;   div_q  <= div_d;
    end
  end

  // ==========================================
  // Sample source and packet builder
  logic [DATA_W-1:0] tg_q, tg_d, samp;
  logic [31:0]       samp_w, td_q, td_d, word, xlen_q, xlen_d, sec_cap_q, sec_cap_d;
  logic [63:0]       frac_cap_q, frac_cap_d, xfrac_q, xfrac_d;
  logic [31:0]       xsec_q, xsec_d, msec_q, msec_d, mlen_q, mlen_d;
  logic [63:0]       mfrac_q, mfrac_d;
  logic [15:0]       wcnt_q, wcnt_d, dwords;
  logic              tv_q, tv_d, tl_q, tl_d, end_q, end_d, xe_q, xe_d, mv_q, mv_d;
  logic              ld, lst, fin, ovf_set, can_load, acq_on;

  assign can_load = !tv_q || dma_tready;
  // Gate mode lets the gate bound the transfer
  assign acq_on = ctrl_q[`APT_CTRL_RUN] && (!ctrl_q[`APT_CTRL_GATE] || gate_in);
  assign fin    = end_q || !acq_on;
  // Short sizes still carry one data word
  assign dwords = (plen_q > `APT_FRAME_WORDS) ? plen_q - `APT_FRAME_WORDS : 16'h0001;

  always_comb begin
    case (apt_pkg::apt_src_t'(ctrl_q[`APT_CTRL_SRC]))
      apt_pkg::APT_SRC_ADC0: samp = adc0_data;
      apt_pkg::APT_SRC_ADC1: samp = adc1_data;
      apt_pkg::APT_SRC_TEST: samp = tg_q;
      default:               samp = '0;
    endcase
    samp_w = {{(32 - DATA_W){1'b0}}, samp};
  end

  always_comb begin
    st_d = st_q;  wcnt_d = wcnt_q;  xlen_d = xlen_q;  end_d = end_q;
    sec_cap_d = sec_cap_q;  frac_cap_d = frac_cap_q;  xsec_d = xsec_q;  xfrac_d = xfrac_q;
    msec_d = msec_q;  mfrac_d = mfrac_q;  mlen_d = mlen_q;  xlast_d = xlast_q;
    tg_d = sample_valid ? tg_q + DATA_W'(1) : tg_q;
    xe_d = 1'b0;  mv_d = 1'b0;  ld = 1'b0;  lst = 1'b0;  word = 32'h0;  ovf_set = 1'b0;
    case (st_q)
      apt_pkg::APT_IDLE: if (acq_on) st_d = apt_pkg::APT_HDR;
      apt_pkg::APT_HDR: if (can_load) begin
        ld   = 1'b1;
        word = {`APT_PKT_TYPE_SIG, `APT_HDR_FLAGS, plen_q};
        sec_cap_d  = ts_bus.sec;
        frac_cap_d = ts_bus.frac;
        st_d = apt_pkg::APT_SID;
      end
      apt_pkg::APT_SID: if (can_load) begin
        ld   = 1'b1;
        word = sid_q;
        st_d = apt_pkg::APT_TSI;
      end
      apt_pkg::APT_TSI: if (can_load) begin
        ld   = 1'b1;
        word = sec_cap_q;
        st_d = apt_pkg::APT_FRH;
      end
      apt_pkg::APT_FRH: if (can_load) begin
        ld   = 1'b1;
        word = frac_cap_q[63:32];
        st_d = apt_pkg::APT_FRL;
      end
      apt_pkg::APT_FRL: if (can_load) begin
        ld     = 1'b1;
        word   = frac_cap_q[31:0];
        wcnt_d = dwords;
        st_d   = apt_pkg::APT_DATA;
      end
      apt_pkg::APT_DATA: begin
        if (!acq_on) begin
          // Packet closes short; header size is already gone
          end_d = 1'b1;
          st_d  = apt_pkg::APT_TRL;
        end else if (sample_valid) begin
          if (can_load) begin
            ld     = 1'b1;
            word   = samp_w;
            xlen_d = xlen_q + 32'h1;
            wcnt_d = wcnt_q - 16'h0001;
            if (xlen_q == 32'h0) begin
              xsec_d  = ts_bus.sec;
              xfrac_d = ts_bus.frac;
            end
            if (wcnt_q == 16'h0001) st_d = apt_pkg::APT_TRL;
          end else begin
            // No buffer: a stalled sink drops samples
            ovf_set = 1'b1;
          end
        end
      end
      apt_pkg::APT_TRL: if (can_load) begin
        ld   = 1'b1;
        lst  = 1'b1;
        word = {trl_q[31:1], fin};
        if (fin) begin
          xe_d    = 1'b1;
          mv_d    = ctrl_q[`APT_CTRL_META];
          msec_d  = xsec_q;
          mfrac_d = xfrac_q;
          mlen_d  = xlen_q;
          xlast_d = xlen_q;
          xlen_d  = 32'h0;
          end_d   = 1'b0;
          st_d    = apt_pkg::APT_IDLE;
        end else begin
          st_d = apt_pkg::APT_HDR;
        end
      end
      default: st_d = apt_pkg::APT_IDLE;
    endcase
    tv_d = ld || (tv_q && !dma_tready);
    td_d = ld ? word : td_q;
    tl_d = ld ? lst : tl_q;
    ovf_d = ovf_set || (ovf_q && !ovf_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= apt_pkg::APT_IDLE;  wcnt_q <= 16'h0000;  xlen_q <= 32'h0;  end_q <= 1'b0;
      sec_cap_q <= 32'h0;  frac_cap_q <= 64'h0;  xsec_q <= 32'h0;  xfrac_q <= 64'h0;
      msec_q <= 32'h0;  mfrac_q <= 64'h0;  mlen_q <= 32'h0;  xlast_q <= 32'h0;
      tg_q <= '0;  xe_q <= 1'b0;  mv_q <= 1'b0;  tv_q <= 1'b0;  td_q <= 32'h0;
      tl_q <= 1'b0;  ovf_q <= 1'b0;
    end else begin
      st_q <= st_d;  wcnt_q <= wcnt_d;  xlen_q <= xlen_d;  end_q <= end_d;
      sec_cap_q <= sec_cap_d;  frac_cap_q <= frac_cap_d;  xsec_q <= xsec_d;  xfrac_q <= xfrac_d;
      msec_q <= msec_d;  mfrac_q <= mfrac_d;  mlen_q <= mlen_d;  xlast_q <= xlast_d;
      tg_q <= tg_d;  xe_q <= xe_d;  mv_q <= mv_d;  tv_q <= tv_d;  td_q <= td_d;
      tl_q <= tl_d;  ovf_q <= ovf_d;
    end
  end

  assign dma_tdata  = td_q;
  assign dma_tvalid = tv_q;
  assign dma_tlast  = tl_q;
  assign xfer_end   = xe_q;
  assign meta_valid = mv_q;
  assign meta_chan  = CHAN_ID;
  assign meta_sec   = msec_q;
  assign meta_frac  = mfrac_q;
  assign meta_len   = mlen_q;

  // ==========================================
  // Playback framing strip
  logic [2:0]  pbi_q, pbi_d;
  logic [31:0] txd_q, txd_d;
  logic        txv_q, txv_d;

  assign pb_tready = 1'b1;

  always_comb begin
    pbi_d = pbi_q;
    txd_d = txd_q;
    txv_d = 1'b0;
    if (pb_tvalid) begin
      if (pb_tlast) begin
        pbi_d = 3'h0;
      end else if (pbi_q == `APT_PB_DATA_IDX) begin
        txv_d = 1'b1;
        txd_d = pb_tdata;
      end else begin
        pbi_d = pbi_q + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pbi_q <= 3'h0;
      txd_q <= 32'h0;
      txv_q <= 1'b0;
    end else begin
      pbi_q <= pbi_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
    end
  end

  assign tx_data  = txd_q;
  assign tx_valid = txv_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  hdr_word_a: assert property (ld && st_q == apt_pkg::APT_HDR |=> dma_tdata[31:28] == `APT_PKT_TYPE_SIG && dma_tdata[15:0] == $past(plen_q))
    else $error("header word wrong");
  sid_word_a: assert property (ld && st_q == apt_pkg::APT_SID |=> dma_tdata == $past(sid_q) && !dma_tlast)
    else $error("stream id word wrong");
  ts_word_a: assert property (ld && st_q == apt_pkg::APT_HDR ##1 ld && st_q == apt_pkg::APT_SID ##1 ld |=> dma_tdata == $past(ts_bus.sec, 3))
    else $error("seconds word not from counter");
  src_sel_a: assert property (ld && st_q == apt_pkg::APT_DATA && ctrl_q[`APT_CTRL_SRC] == 2'h1 |=> dma_tdata == {{(32 - DATA_W){1'b0}}, $past(adc1_data)})
    else $error("source select wrong");
  gate_end_a: assert property (st_q == apt_pkg::APT_DATA && !acq_on |=> st_q == apt_pkg::APT_TRL ##0 end_q)
    else $error("gate end did not close transfer");
  meta_rec_a: assert property (meta_valid |-> xfer_end && meta_len == xlast_q && meta_chan == CHAN_ID)
    else $error("metadata record wrong");
  strip_a: assert property (tx_valid |-> $past(pb_tvalid) && !$past(pb_tlast) && tx_data == $past(pb_tdata))
    else $error("framing word forwarded");
  pkt_last_a: assert property (dma_tvalid && dma_tlast && dma_tready |=> !dma_tvalid || !dma_tlast)
    else $error("trailer repeated");
endmodule : apt_top
`default_nettype wire

//--- verif/apt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apt_host_model (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   stall,
  output logic        dma_tready,
  output logic [31:0] pb_tdata,
  output logic        pb_tvalid,
  output logic        pb_tlast,
  input  wire logic   pb_tready
);
  // ==========================================
  // Capture side: a slow host takes every other word
  always_ff @(posedge aclk) begin
    if (!aresetn)
      dma_tready <= 1'b1;
    else
      dma_tready <= stall ? !dma_tready : 1'b1;
  end
  // ==========================================
  // Playback side: whole framed packets, five framing words first
  initial begin
    pb_tvalid = 1'b0;
    pb_tlast  = 1'b0;
    pb_tdata  = 32'h0;
  end
  task automatic send_pkt(input logic [31:0] base, input int n);
    int i;
    @(posedge aclk);
    for (i = 0; i < n; i++) begin
      pb_tdata  <= base + i;
      pb_tvalid <= 1'b1;
      pb_tlast  <= (i == n - 1);
      @(posedge aclk);
      while (!pb_tready) @(posedge aclk);
    end
    pb_tvalid <= 1'b0;
    pb_tlast  <= 1'b0;
    // Released data must not look like a held word
    pb_tdata  <= ~pb_tdata;
  endtask : send_pkt
endmodule : apt_host_model
`default_nettype wire

//--- verif/acquisition_packet_timestamper_test.sv
`timescale 1ns/1ps
`default_nettype none
module acquisition_packet_timestamper_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, meta_chan;
  logic [31:0] wdata, rdata, dma_tdata, pb_tdata, tx_data, meta_sec, meta_len, m_sec, m_len, v, sec_exp;
  logic [1:0] bresp, rresp, r;
  logic [15:0] adc0, adc1;
  logic sample_valid, gate_in, pps_in, dma_tvalid, dma_tready, dma_tlast, xfer_end, meta_valid;
  logic pb_tvalid, pb_tready, pb_tlast, tx_valid, stall;
  logic [7:0] m_chan;
  logic [63:0] meta_frac, m_frac;
  logic [32:0] pkt[$];
  logic [31:0] txq[$];
  int n_errors, checked, n_xfer, i, s, npk;
  apt_top #(.DATA_W(16), .CHAN_ID(8'h5a)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .adc0_data(adc0), .adc1_data(adc1), .sample_valid(sample_valid),
    .gate_in(gate_in), .pps_in(pps_in), .dma_tdata(dma_tdata), .dma_tvalid(dma_tvalid),
    .dma_tready(dma_tready), .dma_tlast(dma_tlast), .xfer_end(xfer_end), .meta_valid(meta_valid),
    .meta_chan(meta_chan), .meta_sec(meta_sec), .meta_frac(meta_frac), .meta_len(meta_len), .pb_tdata(pb_tdata),
    .pb_tvalid(pb_tvalid), .pb_tready(pb_tready), .pb_tlast(pb_tlast), .tx_data(tx_data), .tx_valid(tx_valid));
  apt_host_model host (.aclk(aclk), .aresetn(aresetn), .stall(stall), .dma_tready(dma_tready),
    .pb_tdata(pb_tdata), .pb_tvalid(pb_tvalid), .pb_tlast(pb_tlast), .pb_tready(pb_tready));
  // ==========================================
  // Clock, monitors, checks
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (dma_tvalid === 1'b1 && dma_tready === 1'b1) pkt.push_back({dma_tlast, dma_tdata});
    if (tx_valid === 1'b1) txq.push_back(tx_data);
    if (xfer_end === 1'b1) n_xfer++;
    if (meta_valid === 1'b1) begin
      m_chan = meta_chan;
      m_sec = meta_sec;
      m_frac = meta_frac;
      m_len = meta_len;
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
  // ==========================================
  // Bus master and stimulus tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the answer
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, r);
    chk(r, 2'b00);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, v, r);
    chk({r, v}, {2'b00, e});
  endtask : rd_chk
  task automatic pulse_pps;
    @(posedge aclk);
    pps_in <= 1'b1;
    @(posedge aclk);
    pps_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse_pps
  task automatic wait_words(input int k);
    for (int n = 0; n < 2000 && pkt.size() < k; n++) @(posedge aclk);
    if (pkt.size() < k) n_errors++;
  endtask : wait_words
  task automatic wait_xfer(input int k);
    for (int n = 0; n < 2000 && n_xfer < k; n++) @(posedge aclk);
    // A stalled sink may take the trailer after the end pulse
    repeat (4) @(posedge aclk);
    chk(n_xfer, k);
  endtask : wait_xfer
  // ==========================================
  // Test sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, gate_in, pps_in, stall} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    adc0 = 16'h1111;
    adc1 = 16'h2222;
    sample_valid = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h100);
    rd_chk(8'h14, 32'h1);
    rd_chk(8'h18, 32'h0);
    axi_rd(8'h40, v, r);
    chk({r, v}, {2'b10, 32'h0});
    axi_wr(8'h24, 32'h5, r);
    chk(r, 2'b10);
    wr(8'h18, 32'h10);
    rd_chk(8'h18, 32'h10);
    wr(8'h00, 32'h8);
    pulse_pps;
    pulse_pps;
    rd_chk(8'h18, 32'h12);
    wr(8'h18, 32'h99);
    rd_chk(8'h18, 32'h12);
    wr(8'h14, 32'h4);
    repeat (400) @(posedge aclk);
    axi_rd(8'h20, v, r);
    chk(v > 32'h40, 1'b1);
    rd_chk(8'h1c, 32'h0);
    pulse_pps;
    axi_rd(8'h20, v, r);
    chk(v < 32'h8, 1'b1);
    sec_exp = 32'h13;
    wr(8'h08, 32'h8);
    wr(8'h0c, 32'habcd0001);
    wr(8'h10, 32'h5a5a5a50);
    for (s = 0; s < 4; s++) begin
      stall <= (s != 2);
      pkt.delete();
      wr(8'h00, {26'h0, s[1:0], 4'h1});
      wait_words(8);
      wr(8'h00, 32'h0);
      wait_xfer(s + 1);
      chk(pkt[0], {1'b0, 4'h1, 12'h461, 16'h0008});
      chk(pkt[1], {1'b0, 32'habcd0001});
      chk(pkt[2], {1'b0, sec_exp});
      if (s == 2)
        chk(pkt[6] - pkt[5], 33'h1);
      else
        chk(pkt[5], (s == 0) ? 33'h1111 : (s == 1) ? 33'h2222 : 33'h0);
      chk(pkt[7], {1'b1, 32'h5a5a5a50});
      chk(pkt[pkt.size() - 1], {1'b1, 32'h5a5a5a51});
    end
    // Stalled runs drop samples, so the overrun flag is up
    rd_chk(8'h04, 32'h8);
    wr(8'h04, 32'h8);
    rd_chk(8'h04, 32'h0);
    stall <= 1'b0;
    pkt.delete();
    wr(8'h00, 32'h7);
    repeat (20) @(posedge aclk);
    chk(pkt.size(), 0);
    gate_in <= 1'b1;
    repeat (40) @(posedge aclk);
    gate_in <= 1'b0;
    wait_xfer(5);
    chk(pkt[pkt.size() - 1], {1'b1, 32'h5a5a5a51});
    npk = 0;
    foreach (pkt[i]) npk += pkt[i][32];
    chk(m_len, pkt.size() - 6 * npk);
    chk(m_chan, 8'h5a);
    chk(m_sec, sec_exp);
    chk(m_frac[63:32], pkt[3][31:0]);
    // First sample is five words after the header capture
    chk((m_frac[31:0] - pkt[4][31:0] - 32'h1) < 32'h2, 1'b1);
    rd_chk(8'h24, m_len);
    for (i = 0; i < 2; i++) host.send_pkt(32'h100 * (i + 1), 8);
    repeat (5) @(posedge aclk);
    chk(txq.size(), 4);
    chk(txq[0], 32'h105);
    chk(txq[1], 32'h106);
    chk(txq[3], 32'h206);
    print_verdict;
  end
endmodule : acquisition_packet_timestamper_test
`default_nettype wire
